// File: pkg/bsu_pkg.sv
// Package for the barrel shifter unit: register map, opcodes, field layouts and shared types
//
// Functional notes
// - Shifter uses only the 32-bit fixed field
// - Immediate second operand only in type 6
// - Same opcode for register or immediate operand
// - Decode 0x00 logical, 0x04 arithmetic shift
// - Decode 0x20, 0x24 as OR-merged shifts
// - Decode the six single-operand opcodes
// - Report sign-fill and wide-scale modifiers
// - Logical shift without sign fill
// - Arithmetic shift of the fixed field
// - Register count uses whole 32-bit value
// - Positive count left, negative count right
// - Immediate count is signed 8-bit
// - Large counts shift the field fully out
// - OR-merged forms OR with destination field
// - Shift writes clear destination extension bits
// - Zero flag reflects shifted result
// - Overflow on left count, sign flag cleared
package bsu_pkg;

    localparam int          BSU_ADDR_W      = 8;
    localparam int          BSU_FIX_W       = 32;

    // Register byte offsets
    localparam logic [7:0]  BSU_CMD_OFS     = 8'h00;
    localparam logic [7:0]  BSU_XFIX_OFS    = 8'h04;
    localparam logic [7:0]  BSU_YFIX_OFS    = 8'h08;
    localparam logic [7:0]  BSU_IMM_OFS     = 8'h0c;
    localparam logic [7:0]  BSU_DFIX_OFS    = 8'h10;
    localparam logic [7:0]  BSU_DEXT_OFS    = 8'h14;
    localparam logic [7:0]  BSU_STAT_OFS    = 8'h18;

    // Status bit positions
    localparam int          BSU_ST_ZERO     = 0;
    localparam int          BSU_ST_OVF      = 1;
    localparam int          BSU_ST_SIGN     = 2;
    localparam int          BSU_ST_DONE     = 3;
    localparam int          BSU_ST_ILLEGAL  = 4;
    localparam int          BSU_ST_WROTE    = 5;
    localparam int          BSU_ST_SFILL    = 6;
    localparam int          BSU_ST_WIDE     = 7;
    localparam int          BSU_ST_CLASS    = 8;

    localparam logic [3:0]  BSU_TYPE_IMM    = 4'h6;
    localparam logic [1:0]  BSU_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  BSU_RESP_SLVERR = 2'h2;
    localparam logic [31:0] BSU_WORD_RST    = 32'h0000_0000;

    // Shifter opcodes
    localparam logic [7:0]  BSU_OPC_LSH     = 8'h00;
    localparam logic [7:0]  BSU_OPC_LSH_OR  = 8'h20;
    localparam logic [7:0]  BSU_OPC_ASH     = 8'h04;
    localparam logic [7:0]  BSU_OPC_ASH_OR  = 8'h24;
    localparam logic [7:0]  BSU_OPC_TURN    = 8'h08;
    localparam logic [7:0]  BSU_OPC_BCLR    = 8'hc4;
    localparam logic [7:0]  BSU_OPC_BSET    = 8'hc0;
    localparam logic [7:0]  BSU_OPC_BTGL    = 8'hc8;
    localparam logic [7:0]  BSU_OPC_BTST    = 8'hcc;
    localparam logic [7:0]  BSU_OPC_DEP     = 8'h44;
    localparam logic [7:0]  BSU_OPC_DEP_OR  = 8'h64;
    localparam logic [7:0]  BSU_OPC_DEP_SF  = 8'h4c;
    localparam logic [7:0]  BSU_OPC_DEP_OSF = 8'h6c;
    localparam logic [7:0]  BSU_OPC_XTR     = 8'h40;
    localparam logic [7:0]  BSU_OPC_XTR_SF  = 8'h48;
    localparam logic [7:0]  BSU_OPC_SCALE   = 8'h80;
    localparam logic [7:0]  BSU_OPC_SCALE_W = 8'h84;
    localparam logic [7:0]  BSU_OPC_LZC     = 8'h88;
    localparam logic [7:0]  BSU_OPC_LOC     = 8'h8c;
    localparam logic [7:0]  BSU_OPC_FPK     = 8'h90;
    localparam logic [7:0]  BSU_OPC_FUPK    = 8'h94;

    typedef enum logic [4:0] {
        BSU_OP_ILLEGAL   = 5'b00000,
        BSU_OP_LOGICAL   = 5'b00001,
        BSU_OP_LOGICAL_O = 5'b00010,
        BSU_OP_ARITH     = 5'b00011,
        BSU_OP_ARITH_O   = 5'b00100,
        BSU_OP_TURN      = 5'b00101,
        BSU_OP_BCLR      = 5'b00110,
        BSU_OP_BSET      = 5'b00111,
        BSU_OP_BTGL      = 5'b01000,
        BSU_OP_BTST      = 5'b01001,
        BSU_OP_DEPOSIT   = 5'b01010,
        BSU_OP_DEPOSIT_O = 5'b01011,
        BSU_OP_EXTRACT   = 5'b01100,
        BSU_OP_SCALE     = 5'b01101,
        BSU_OP_LEAD_ZERO = 5'b01110,
        BSU_OP_LEAD_ONE  = 5'b01111,
        BSU_OP_PACK      = 5'b10000,
        BSU_OP_UNPACK    = 5'b10001
    } bsu_op_t;

    typedef struct packed {
        logic [3:0] instType;
        logic [7:0] opcode;
    } bsu_cmd_t;

    typedef struct packed {
        logic [31:0] fix;
        logic [7:0]  ext;
    } bsu_word_t;

    typedef struct packed {
        logic sign;
        logic ovf;
        logic zero;
    } bsu_flags_t;

endpackage

// File: rtl/bsu_shifter.sv
// Barrel shifter unit with opcode decoder and AXI4-Lite register slave
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module bsu_shifter (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // Write address channel
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // Write data channel
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // Write response channel
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Read address channel
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // Read data channel
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    logic               awreadyQ;
    logic               wreadyQ;
    logic               bvalidQ;
    logic               arreadyQ;
    logic               rvalidQ;
    logic [1:0]         brespQ;
    logic [1:0]         rrespQ;
    logic [31:0]        rdataQ;
    logic [7:0]         awaddrQ;
    logic [31:0]        wdataQ;
    logic [3:0]         wstrbQ;
    logic [31:0]        wrMask;
    logic               wrEn;
    logic               wrHit;
    logic               startQ;
    bsu_pkg::bsu_cmd_t  cmdQ;
    logic [31:0]        xFixQ;
    logic [31:0]        yFixQ;
    logic [7:0]         immQ;
    bsu_pkg::bsu_word_t destQ;
    bsu_pkg::bsu_flags_t flagsQ;
    logic               doneQ;
    logic               illegalQ;
    logic               wroteQ;
    logic               signFillQ;
    logic               wideQ;
    bsu_pkg::bsu_op_t   opQ;
    bsu_pkg::bsu_op_t   opCur;
    logic signed [31:0] cnt;
    logic signed [31:0] xSigned;
    logic signed [31:0] arithR;
    logic [4:0]         rAmt;
    logic               cntPos;
    logic               bigLeft;
    logic               bigRight;
    logic               isShift;
    logic               isArith;
    logic               isOr;
    logic [31:0]        shifted;
    logic [31:0]        newFix;
    logic [31:0]        statVal;
    logic [31:0]        rdVal;
    logic               rdHit;

    assign s_axi_awready = awreadyQ;
    assign s_axi_wready  = wreadyQ;
    assign s_axi_bvalid  = bvalidQ;
    assign s_axi_bresp   = brespQ;
    assign s_axi_arready = arreadyQ;
    assign s_axi_rvalid  = rvalidQ;
    assign s_axi_rdata   = rdataQ;
    assign s_axi_rresp   = rrespQ;

    function automatic bsu_pkg::bsu_op_t decodeOp(input logic [7:0] opc);
        unique case (opc)
            bsu_pkg::BSU_OPC_LSH:     decodeOp = bsu_pkg::BSU_OP_LOGICAL;
            bsu_pkg::BSU_OPC_ASH:     decodeOp = bsu_pkg::BSU_OP_ARITH;
            bsu_pkg::BSU_OPC_LSH_OR:  decodeOp = bsu_pkg::BSU_OP_LOGICAL_O;
            bsu_pkg::BSU_OPC_ASH_OR:  decodeOp = bsu_pkg::BSU_OP_ARITH_O;
            bsu_pkg::BSU_OPC_TURN:    decodeOp = bsu_pkg::BSU_OP_TURN;
            bsu_pkg::BSU_OPC_BCLR:    decodeOp = bsu_pkg::BSU_OP_BCLR;
            bsu_pkg::BSU_OPC_BSET:    decodeOp = bsu_pkg::BSU_OP_BSET;
            bsu_pkg::BSU_OPC_BTGL:    decodeOp = bsu_pkg::BSU_OP_BTGL;
            bsu_pkg::BSU_OPC_BTST:    decodeOp = bsu_pkg::BSU_OP_BTST;
            bsu_pkg::BSU_OPC_DEP,
            bsu_pkg::BSU_OPC_DEP_SF:  decodeOp = bsu_pkg::BSU_OP_DEPOSIT;
            bsu_pkg::BSU_OPC_DEP_OR,
            bsu_pkg::BSU_OPC_DEP_OSF: decodeOp = bsu_pkg::BSU_OP_DEPOSIT_O;
            bsu_pkg::BSU_OPC_XTR,
            bsu_pkg::BSU_OPC_XTR_SF:  decodeOp = bsu_pkg::BSU_OP_EXTRACT;
            bsu_pkg::BSU_OPC_SCALE,
            bsu_pkg::BSU_OPC_SCALE_W: decodeOp = bsu_pkg::BSU_OP_SCALE;
            bsu_pkg::BSU_OPC_LZC:     decodeOp = bsu_pkg::BSU_OP_LEAD_ZERO;
            bsu_pkg::BSU_OPC_LOC:     decodeOp = bsu_pkg::BSU_OP_LEAD_ONE;
            bsu_pkg::BSU_OPC_FPK:     decodeOp = bsu_pkg::BSU_OP_PACK;
            bsu_pkg::BSU_OPC_FUPK:    decodeOp = bsu_pkg::BSU_OP_UNPACK;
            default:                  decodeOp = bsu_pkg::BSU_OP_ILLEGAL;
        endcase
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [31:0] m);
        merge = (old & ~m) | (val & m);
    endfunction

    // Byte strobes widened to a bit mask
    for (genvar i = 0; i < 4; i++) begin : g_mask
        assign wrMask[8*i +: 8] = {8{wstrbQ[i]}};
    end

    // A write completes only once address and data are both held and the last response has gone
    assign wrEn  = ~awreadyQ & ~wreadyQ & ~bvalidQ;
    assign wrHit = (awaddrQ == bsu_pkg::BSU_CMD_OFS) || (awaddrQ == bsu_pkg::BSU_XFIX_OFS) ||
                   (awaddrQ == bsu_pkg::BSU_YFIX_OFS) || (awaddrQ == bsu_pkg::BSU_IMM_OFS) ||
                   (awaddrQ == bsu_pkg::BSU_DFIX_OFS) || (awaddrQ == bsu_pkg::BSU_DEXT_OFS);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            awreadyQ <= 1'b1;
            awaddrQ  <= 8'h00;
        end else if (s_axi_awvalid && awreadyQ) begin
            awreadyQ <= 1'b0;
            awaddrQ  <= s_axi_awaddr;
        end else if (wrEn) begin
            awreadyQ <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wreadyQ <= 1'b1;
            wdataQ  <= 32'h0000_0000;
            wstrbQ  <= 4'h0;
        end else if (s_axi_wvalid && wreadyQ) begin
            wreadyQ <= 1'b0;
            wdataQ  <= s_axi_wdata;
            wstrbQ  <= s_axi_wstrb;
        end else if (wrEn) begin
            wreadyQ <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            bvalidQ <= 1'b0;
            brespQ  <= bsu_pkg::BSU_RESP_OKAY;
        end else if (wrEn) begin
            bvalidQ <= 1'b1;
            brespQ  <= wrHit ? bsu_pkg::BSU_RESP_OKAY : bsu_pkg::BSU_RESP_SLVERR;
        end else if (bvalidQ && s_axi_bready) begin
            bvalidQ <= 1'b0;
        end
    end

    // Operand registers; a command write starts one operation in the following cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cmdQ   <= '0;
            xFixQ  <= bsu_pkg::BSU_WORD_RST;
            yFixQ  <= bsu_pkg::BSU_WORD_RST;
            immQ   <= 8'h00;
            startQ <= 1'b0;
        end else begin
            startQ <= wrEn && (awaddrQ == bsu_pkg::BSU_CMD_OFS);
            if (wrEn) begin
                unique case (awaddrQ)
                    bsu_pkg::BSU_CMD_OFS:  cmdQ  <= 12'(merge({20'h0_0000, cmdQ}, wdataQ, wrMask));
                    bsu_pkg::BSU_XFIX_OFS: xFixQ <= merge(xFixQ, wdataQ, wrMask);
                    bsu_pkg::BSU_YFIX_OFS: yFixQ <= merge(yFixQ, wdataQ, wrMask);
                    bsu_pkg::BSU_IMM_OFS:  immQ  <= 8'(merge({24'h00_0000, immQ}, wdataQ, wrMask));
                    default: ;
                endcase
            end
        end
    end

    assign opCur    = decodeOp(cmdQ.opcode);
    // Only type 6 may take the count from the immediate; any other type uses the register
    assign cnt      = (cmdQ.instType == bsu_pkg::BSU_TYPE_IMM) ? {{24{immQ[7]}}, immQ} : yFixQ;
    assign cntPos   = cnt > 0;
    assign bigLeft  = cnt >= bsu_pkg::BSU_FIX_W;
    assign bigRight = cnt <= -bsu_pkg::BSU_FIX_W;
    assign rAmt     = 5'h00 - cnt[4:0];
    assign isArith  = (opCur == bsu_pkg::BSU_OP_ARITH) || (opCur == bsu_pkg::BSU_OP_ARITH_O);
    assign isOr     = (opCur == bsu_pkg::BSU_OP_LOGICAL_O) || (opCur == bsu_pkg::BSU_OP_ARITH_O);
    assign isShift  = isArith || isOr || (opCur == bsu_pkg::BSU_OP_LOGICAL);
    assign xSigned  = xFixQ;
    // Kept apart from the mux so that its signedness is not lost to the unsigned arm
    assign arithR   = xSigned >>> rAmt;

    always_comb begin
        shifted = xFixQ;
        if (bigLeft) begin
            shifted = 32'h0000_0000;
        end else if (cntPos) begin
            shifted = xFixQ << cnt[4:0];
        end else if (bigRight) begin
            shifted = isArith ? {32{xFixQ[31]}} : 32'h0000_0000;
        end else if (cnt < 0) begin
            shifted = isArith ? arithR : (xFixQ >> rAmt);
        end
    end

    assign newFix = isOr ? (shifted | destQ.fix) : shifted;

    // Destination and flags; the operation wins over a bus write in the same cycle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            destQ  <= '0;
            flagsQ <= '0;
        end else if (startQ && isShift) begin
            destQ.fix   <= newFix;
            destQ.ext   <= 8'h00;
            flagsQ.zero <= (shifted == 32'h0000_0000);
            flagsQ.ovf  <= cntPos;
            flagsQ.sign <= 1'b0;
        end else if (wrEn && (awaddrQ == bsu_pkg::BSU_DFIX_OFS)) begin
            destQ.fix <= merge(destQ.fix, wdataQ, wrMask);
        end else if (wrEn && (awaddrQ == bsu_pkg::BSU_DEXT_OFS)) begin
            destQ.ext <= 8'(merge({24'h00_0000, destQ.ext}, wdataQ, wrMask));
        end
    end

    // Other decoded classes are reported but leave destination and flags alone
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            doneQ     <= 1'b0;
            illegalQ  <= 1'b0;
            wroteQ    <= 1'b0;
            signFillQ <= 1'b0;
            wideQ     <= 1'b0;
            opQ       <= bsu_pkg::BSU_OP_ILLEGAL;
        end else if (startQ) begin
            doneQ     <= 1'b1;
            illegalQ  <= (opCur == bsu_pkg::BSU_OP_ILLEGAL);
            wroteQ    <= isShift;
            signFillQ <= ((opCur == bsu_pkg::BSU_OP_DEPOSIT) || (opCur == bsu_pkg::BSU_OP_DEPOSIT_O) ||
                          (opCur == bsu_pkg::BSU_OP_EXTRACT)) && cmdQ.opcode[3];
            wideQ     <= (opCur == bsu_pkg::BSU_OP_SCALE) && cmdQ.opcode[2];
            opQ       <= opCur;
        end else if (wrEn && (awaddrQ == bsu_pkg::BSU_CMD_OFS)) begin
            doneQ <= 1'b0;
        end
    end

    always_comb begin
        statVal = 32'h0000_0000;
        statVal[bsu_pkg::BSU_ST_ZERO]    = flagsQ.zero;
        statVal[bsu_pkg::BSU_ST_OVF]     = flagsQ.ovf;
        statVal[bsu_pkg::BSU_ST_SIGN]    = flagsQ.sign;
        statVal[bsu_pkg::BSU_ST_DONE]    = doneQ;
        statVal[bsu_pkg::BSU_ST_ILLEGAL] = illegalQ;
        statVal[bsu_pkg::BSU_ST_WROTE]   = wroteQ;
        statVal[bsu_pkg::BSU_ST_SFILL]   = signFillQ;
        statVal[bsu_pkg::BSU_ST_WIDE]    = wideQ;
        statVal[bsu_pkg::BSU_ST_CLASS +: 5] = opQ;
    end

    always_comb begin
        rdHit = 1'b1;
        unique case (s_axi_araddr)
            bsu_pkg::BSU_CMD_OFS:  rdVal = {20'h0_0000, cmdQ};
            bsu_pkg::BSU_XFIX_OFS: rdVal = xFixQ;
            bsu_pkg::BSU_YFIX_OFS: rdVal = yFixQ;
            bsu_pkg::BSU_IMM_OFS:  rdVal = {24'h00_0000, immQ};
            bsu_pkg::BSU_DFIX_OFS: rdVal = destQ.fix;
            bsu_pkg::BSU_DEXT_OFS: rdVal = {24'h00_0000, destQ.ext};
            bsu_pkg::BSU_STAT_OFS: rdVal = statVal;
            default: begin
                rdVal = 32'h0000_0000;
                rdHit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            arreadyQ <= 1'b1;
            rvalidQ  <= 1'b0;
            rdataQ   <= 32'h0000_0000;
            rrespQ   <= bsu_pkg::BSU_RESP_OKAY;
        end else if (s_axi_arvalid && arreadyQ) begin
            arreadyQ <= 1'b0;
            rvalidQ  <= 1'b1;
            rdataQ   <= rdVal;
            rrespQ   <= rdHit ? bsu_pkg::BSU_RESP_OKAY : bsu_pkg::BSU_RESP_SLVERR;
        end else if (rvalidQ && s_axi_rready) begin
            rvalidQ  <= 1'b0;
            arreadyQ <= 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    logic xSign;
    logic isLogicalPlain;
    assign xSign          = xFixQ[31];
    assign isLogicalPlain = opCur == bsu_pkg::BSU_OP_LOGICAL;

    sequence execDone;
        ##1 doneQ && wroteQ;
    endsequence

    sequence destHeld;
        ##1 $stable(destQ) && !wroteQ;
    endsequence

    logical_decode_a: assert property (startQ && cmdQ.opcode == bsu_pkg::BSU_OPC_LSH |-> execDone)
        else $error("logical shift opcode did not complete with a write");
    btst_nowrite_a: assert property (startQ && opCur == bsu_pkg::BSU_OP_BTST |-> destHeld)
        else $error("bit test changed the destination");
    count_source_a: assert property (startQ && cmdQ.instType != bsu_pkg::BSU_TYPE_IMM |-> cnt == yFixQ)
        else $error("non-immediate type did not use the register count");
    ext_clear_a: assert property (startQ && isShift |=> destQ.ext == 8'h00 && !flagsQ.sign)
        else $error("shift left extension bits or sign flag set");
    ovf_flag_a: assert property (startQ && isShift |=> flagsQ.ovf == $past(cntPos))
        else $error("overflow flag does not match the count direction");
    zero_count_a: assert property (startQ && isShift && cnt == 0 && !isOr |=> destQ.fix == $past(xFixQ))
        else $error("zero count altered the operand");
    zero_flag_a: assert property (startQ && isShift && cnt == 0 |=> flagsQ.zero == ($past(xFixQ) == 32'h0))
        else $error("zero flag wrong for unshifted operand");
    full_out_a: assert property (startQ && isLogicalPlain && (bigLeft || bigRight) |=> destQ.fix == 32'h0)
        else $error("large count did not clear the field");
    arith_fill_a: assert property (startQ && opCur == bsu_pkg::BSU_OP_ARITH && bigRight
                                   |=> destQ.fix == {32{$past(xSign)}})
        else $error("arithmetic right shift did not fill with sign");
    or_keep_a: assert property (startQ && isShift && isOr
                                |=> (destQ.fix & $past(destQ.fix)) == $past(destQ.fix))
        else $error("OR-merged shift lost destination bits");

endmodule

// File: testbench/bsu_host_model.sv
// Register-file side model: AXI4-Lite master that issues single reads and writes
`timescale 1ns/100ps
module bsu_host_model (
    // Clock
    input  wire logic        mclk,
    // Write channels
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // Read channels
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end

    // Outputs are flops, so values read just after an edge are those the edge sampled
    // Response readies stay high between transfers so that no edge sees them dropped and raised at once
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw;
        logic w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (!aw && !w && s_axi_bvalid) begin
                r = s_axi_bresp;
                break;
            end
            if (aw && s_axi_awready) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w && s_axi_wready) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar;
        ar = 1'b1;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (!ar && s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                break;
            end
            if (ar && s_axi_arready) begin
                ar = 1'b0;
                s_axi_arvalid <= 1'b0;
            end
        end
    endtask
endmodule

// File: testbench/barrel_shifter_unit_bench.sv
// Self-checking bench for the barrel shifter unit
`timescale 1ns/100ps
module barrel_shifter_unit_bench;
    logic        mclk, arst_n;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          errors, tests_run;
    logic [2:0]  flags;
    logic [7:0]  oth [17] = '{8'h08, 8'hc4, 8'hc0, 8'hc8, 8'hcc, 8'h44, 8'h64, 8'h4c, 8'h6c,
                              8'h40, 8'h48, 8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94};
    logic [4:0]  cls [17] = '{5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0a, 5'h0b,
                              5'h0c, 5'h0c, 5'h0d, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11};
    logic [3:0]  wrStrb = 4'hf;

    bsu_shifter dut (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    bsu_host_model host (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, s, e);
        end
    endtask

    task automatic test_done();
        if (errors == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        host.wr(a, d, wrStrb, r);
        chk({30'h0, r}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        host.rd(a, d, r);
        chk({30'h0, r}, {30'h0, er});
        chk(d, e);
    endtask

    // Reference shift: counts at or beyond the field width push everything out
    function automatic logic [31:0] shf(input logic [31:0] x, input logic signed [31:0] c, input logic ar);
        if (c >= 32) return 32'h0;
        if (c >= 0) return x << c;
        if (c <= -32) return ar ? {32{x[31]}} : 32'h0;
        return ar ? 32'($signed(x) >>> (-c)) : x >> (-c);
    endfunction

    task automatic op(input logic [7:0] opc, input logic [3:0] ty, input logic [31:0] x, input logic [31:0] y,
                      input logic [7:0] im, input logic [31:0] dold);
        logic signed [31:0] c;
        logic [31:0]        s;
        logic [4:0]         k;
        c = (ty == bsu_pkg::BSU_TYPE_IMM) ? {{24{im[7]}}, im} : y;
        s = shf(x, c, opc[2]);
        k = 5'd1 + {3'd0, opc[2], 1'b0} + {4'd0, opc[5]};
        flags = {1'b0, c > 0, s == 32'h0};
        wr(bsu_pkg::BSU_XFIX_OFS, x, 2'h0);
        wr(bsu_pkg::BSU_YFIX_OFS, y, 2'h0);
        wr(bsu_pkg::BSU_IMM_OFS, {24'h0, im}, 2'h0);
        wr(bsu_pkg::BSU_DFIX_OFS, dold, 2'h0);
        wr(bsu_pkg::BSU_DEXT_OFS, 32'h0000_00a5, 2'h0);
        wr(bsu_pkg::BSU_CMD_OFS, {20'h0, ty, opc}, 2'h0);
        rd(bsu_pkg::BSU_DFIX_OFS, opc[5] ? (s | dold) : s, 2'h0);
        rd(bsu_pkg::BSU_DEXT_OFS, 32'h0, 2'h0);
        rd(bsu_pkg::BSU_STAT_OFS, {19'h0, k, 5'b00101, flags}, 2'h0);
    endtask

    initial begin
        errors = 0;
        tests_run = 0;
        arst_n = 1'b0;
        repeat (5) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        rd(bsu_pkg::BSU_STAT_OFS, 32'h0, 2'h0);
        rd(8'h1c, 32'h0, bsu_pkg::BSU_RESP_SLVERR);
        wr(8'h1c, 32'hffff_ffff, bsu_pkg::BSU_RESP_SLVERR);
        wr(bsu_pkg::BSU_STAT_OFS, 32'hffff_ffff, bsu_pkg::BSU_RESP_SLVERR);
        op(8'h00, 4'h0, 32'h8000_0001, 32'h1, 8'h0, 32'h0);
        op(8'h00, 4'h6, 32'hf000_000f, 32'h1, 8'hfc, 32'h0);
        op(8'h04, 4'h6, 32'hf000_000f, 32'h1, 8'hfc, 32'h0);
        op(8'h04, 4'h0, 32'h8000_0000, 32'hffff_ffc0, 8'h0, 32'h0);
        op(8'h04, 4'h0, 32'h8000_0000, 32'hffff_ffe1, 8'h0, 32'h0);
        op(8'h00, 4'h0, 32'h8000_0000, 32'hffff_ffe1, 8'h0, 32'h0);
        op(8'h00, 4'h0, 32'h0000_0001, 32'h20, 8'h0, 32'h0);
        op(8'h00, 4'h0, 32'h0000_0003, 32'h1f, 8'h0, 32'h0);
        op(8'h00, 4'h6, 32'hffff_ffff, 32'h0, 8'h80, 32'h0);
        op(8'h04, 4'h6, 32'h0000_0001, 32'h0, 8'h7f, 32'h0);
        op(8'h00, 4'h2, 32'h0000_0001, 32'h1, 8'h05, 32'h0);
        op(8'h20, 4'h0, 32'h0000_0001, 32'h4, 8'h0, 32'h0000_000f);
        op(8'h24, 4'h6, 32'h0000_0000, 32'h0, 8'h03, 32'h0000_00ff);
        op(8'h24, 4'h0, 32'h8000_0000, 32'hffff_fffc, 8'h0, 32'h0000_0001);
        op(8'h00, 4'h0, 32'h0000_0010, 32'h0, 8'h0, 32'h0);
        op(8'h00, 4'h0, 32'h1234_5678, 32'h4, 8'h0, 32'h0);
        // Decoded but unimplemented ops touch only the status, so the last shift result must survive
        for (int i = 0; i < 17; i++) begin
            wr(bsu_pkg::BSU_CMD_OFS, {24'h0, oth[i]}, 2'h0);
            rd(bsu_pkg::BSU_STAT_OFS, {19'h0, cls[i], oth[i] == 8'h84, oth[i] inside {8'h4c, 8'h6c, 8'h48},
                3'b001, flags}, 2'h0);
            rd(bsu_pkg::BSU_DFIX_OFS, 32'h2345_6780, 2'h0);
        end
        // Only byte lanes 0 and 2 are written, the other lanes keep the last operand
        wrStrb = 4'h5;
        wr(bsu_pkg::BSU_XFIX_OFS, 32'h0000_0000, 2'h0);
        wrStrb = 4'hf;
        rd(bsu_pkg::BSU_XFIX_OFS, 32'h1200_5600, 2'h0);
        wr(bsu_pkg::BSU_CMD_OFS, 32'h0000_00ff, 2'h0);
        rd(bsu_pkg::BSU_STAT_OFS, 32'h0000_001a, 2'h0);
        test_done();
    end

    initial begin
        #(50 * 20000);
        errors++;
        test_done();
    end
endmodule
